/* inc/becr_defines.svh */
/*
 * Offsets, field positions, reset values and fixed read values of the
 * bridge extended configuration register bank.
 * Assumes byte addresses on a 13-bit APB address, one 32-bit word each.
 */
`ifndef BECR_DEFINES_SVH
`define BECR_DEFINES_SVH

`define BECR_AW 13
`define BECR_OFF_LOG0 13'h013c
`define BECR_OFF_LOG1 13'h0140
`define BECR_OFF_LOG2 13'h0144
`define BECR_OFF_LOG3 13'h0148
`define BECR_OFF_VCHDR 13'h0150
`define BECR_OFF_VCCAP1 13'h0154
`define BECR_OFF_VCCAP2 13'h0158
`define BECR_OFF_VCCTL 13'h015c
`define BECR_OFF_VC0CAP 13'h0160
`define BECR_OFF_VC0CTL 13'h0164
`define BECR_OFF_VC0STS 13'h0168
`define BECR_OFF_XGPIO 13'h0300
`define BECR_OFF_XIO 13'h0304
`define BECR_OFF_TMR 13'h0310
`define BECR_OFF_IRQ_STS 13'h1000
`define BECR_OFF_IRQ_MASK 13'h1004
`define BECR_CFG_TOP 13'h0ffc

`define BECR_VC_CAP_ID 16'h0002
`define BECR_VC_CAP_VER 4'h1
`define BECR_VC_NEXT 12'h000
`define BECR_VC0CTL_VAL 32'h8000_00ff

`define BECR_XG_CLR 0
`define BECR_XG_SET 3
`define BECR_XG_OE_CLR 6
`define BECR_XG_OE_SET 9
`define BECR_XG_IN 12
`define BECR_XO_CLR 0
`define BECR_XO_SET 4
`define BECR_XO_OE_CLR 8
`define BECR_XO_OE_SET 12
`define BECR_XO_IN 16

`define BECR_RPL_LSB 0
`define BECR_RPL_EN 12
`define BECR_ACK_LSB 16
`define BECR_ACK_EN 30
`define BECR_RPL_RST 12'h115
`define BECR_ACK_RST 14'h00cd

`define BECR_EV_LOG 0
`define BECR_EV_XG 1
`define BECR_EV_GPI 4
`define BECR_EV_W 8

`endif

/* inc/becr_pkg.sv */
/*
 * Types of the bridge extended configuration register bank.
 * Assumes the constants of becr_defines.svh.
 */
`include "becr_defines.svh"

package becr_pkg;

   // one failing secondary-bus transaction as seen by the error logger
   typedef struct packed {
      logic dac;
      logic [3:0] attr_cbe;
      logic [31:0] attr_ad;
      logic [3:0] cmd_lo;
      logic [3:0] cmd_hi;
      logic [31:0] addr_lo;
      logic [31:0] addr_hi;
   } becr_txn_t;

   typedef struct packed {
      logic [13:0] ack_val;
      logic ack_en;
      logic [11:0] rpl_val;
      logic rpl_en;
   } becr_tmr_t;

endpackage : becr_pkg

/* verilog/becr_regs.sv */
/*
 * Bridge extended configuration registers: sticky secondary transaction
 * log, terminal virtual channel capability, set/clear extended GPIO and
 * extra GPO/GPI, replay and ack latency timer settings, event interrupt.
 * Assumes an APB master on pclk, a power-on reset por_n that is low at
 * least whenever presetn first is, and a logger on pclk pulsing log_valid.
 */
// Function
// [R01] log attribute phase CBE and AD bits 35:0
// [R02] log first address phase command bits 39:36
// [R03] log DAC command bits 43:40, 63:44 zero
// [R04] log first address bits 95:64
// [R05] log DAC second address bits 127:96
// [R06] log read-only, cleared only by power-on
// [R07] VC header reads ID 2, version 1, end
// [R08] GPIO output write-1 clear / set
// [R09] GPIO enable write-1 disable / enable
// [R10] sampled GPIO and GPI levels read-only
// [R11] extra output write-1 clear / set
// [R12] extra output enable write-1 clear / set
// [R13] ack latency value CDh and enable
// [R14] replay value 115h and enable
// [R15] reserved bits and offsets read zero
`timescale 1ns/100ps
`include "becr_defines.svh"

module becr_regs
   import becr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`BECR_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic log_valid,
   input wire becr_txn_t log_txn,
   input wire logic [2:0] xgpio_in,
   output logic [2:0] xgpio_out,
   output logic [2:0] xgpio_oe,
   input wire logic [3:0] gpi_in,
   output logic [3:0] gpo_out,
   output logic [3:0] gpo_oe,
   output becr_tmr_t tmr,
   output logic irq
);

   // ****************************************************************
   // bus handshake
   // ****************************************************************
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic setup;
   logic wr_acc;

   // one wait state: read data is picked in setup, answer in second cycle
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pready_q & pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= psel & penable & ~pready_q;
      end
   end

   function automatic logic wr_hit(input logic [`BECR_AW-1:0] a,
                                   input logic [`BECR_AW-1:0] off);
      wr_hit = (a == off);
   endfunction : wr_hit

   function automatic logic [3:0] set_clr(input logic [3:0] cur,
                                          input logic [3:0] clr,
                                          input logic [3:0] set);
      // set wins when both bits are written together
      set_clr = (cur & ~clr) | set;
   endfunction : set_clr

   // ****************************************************************
   // sticky transaction log
   // ****************************************************************
   logic [127:0] log_q;
   logic [127:0] log_d;

   always_comb begin
      log_d = 128'h0;
      // [R01] attribute phase
      log_d[35:0] = {log_txn.attr_cbe, log_txn.attr_ad};
      // [R02] first command
      log_d[39:36] = log_txn.cmd_lo;
      // [R04] first address
      log_d[95:64] = log_txn.addr_lo;
      // [R03] second command only for dual address
      log_d[43:40] = log_txn.dac ? log_txn.cmd_hi : 4'h0;
      // [R05] second address only for dual address
      log_d[127:96] = log_txn.dac ? log_txn.addr_hi : 32'h0;
   end

   // [R06] survives presetn, only por_n clears it
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         log_q <= 128'h0;
      end else if (log_valid) begin
         log_q <= log_d;
      end
   end

   // ****************************************************************
   // pin input synchronisers
   // ****************************************************************
   logic [6:0] pin_s1_q;
   logic [6:0] pin_s2_q;
   logic [6:0] pin_s3_q;
   logic [6:0] pin_q;
   logic [6:0] pin_chg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 7'h00;
         pin_s2_q <= 7'h00;
         pin_s3_q <= 7'h00;
      end else begin
         pin_s1_q <= {gpi_in, xgpio_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // a level counts once two late stages agree; filters one-cycle glitches
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi++) begin : g_pin
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_q[gi] <= 1'b0;
            end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
               pin_q[gi] <= pin_s3_q[gi];
            end
         end
         assign pin_chg[gi] = (pin_s2_q[gi] == pin_s3_q[gi]) &&
                              (pin_s3_q[gi] != pin_q[gi]);
      end
   endgenerate

   // ****************************************************************
   // extended GPIO and extra GPO
   // ****************************************************************
   logic [2:0] xg_out_q;
   logic [2:0] xg_oe_q;
   logic [3:0] xo_out_q;
   logic [3:0] xo_oe_q;
   logic xg_wr;
   logic xo_wr;

   assign xg_wr = wr_acc && wr_hit(paddr, `BECR_OFF_XGPIO);
   assign xo_wr = wr_acc && wr_hit(paddr, `BECR_OFF_XIO);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xg_out_q <= 3'h0;
         xg_oe_q <= 3'h0;
      end else if (xg_wr) begin
         // [R08] output level clear / set
         xg_out_q <= 3'(set_clr({1'b0, xg_out_q}, {1'b0, pwdata[`BECR_XG_CLR +: 3]},
                                {1'b0, pwdata[`BECR_XG_SET +: 3]}));
         // [R09] driver disable / enable
         xg_oe_q <= 3'(set_clr({1'b0, xg_oe_q}, {1'b0, pwdata[`BECR_XG_OE_CLR +: 3]},
                               {1'b0, pwdata[`BECR_XG_OE_SET +: 3]}));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xo_out_q <= 4'h0;
         xo_oe_q <= 4'h0;
      end else if (xo_wr) begin
         // [R11] extra output clear / set
         xo_out_q <= set_clr(xo_out_q, pwdata[`BECR_XO_CLR +: 4], pwdata[`BECR_XO_SET +: 4]);
         // [R12] extra enable clear / set
         xo_oe_q <= set_clr(xo_oe_q, pwdata[`BECR_XO_OE_CLR +: 4],
                            pwdata[`BECR_XO_OE_SET +: 4]);
      end
   end

   // ****************************************************************
   // timer settings
   // ****************************************************************
   becr_tmr_t tmr_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_q.rpl_val <= `BECR_RPL_RST;
         tmr_q.rpl_en <= 1'b0;
         tmr_q.ack_val <= `BECR_ACK_RST;
         tmr_q.ack_en <= 1'b0;
      end else if (wr_acc && wr_hit(paddr, `BECR_OFF_TMR)) begin
         // [R14] replay value and enable
         tmr_q.rpl_val <= pwdata[`BECR_RPL_LSB +: 12];
         tmr_q.rpl_en <= pwdata[`BECR_RPL_EN];
         // [R13] ack latency value and enable
         tmr_q.ack_val <= pwdata[`BECR_ACK_LSB +: 14];
         tmr_q.ack_en <= pwdata[`BECR_ACK_EN];
      end
   end

   // ****************************************************************
   // interrupt status and mask
   // ****************************************************************
   logic [`BECR_EV_W-1:0] sts_q;
   logic [`BECR_EV_W-1:0] mask_q;
   logic [`BECR_EV_W-1:0] ev;
   logic [`BECR_EV_W-1:0] sts_clr;
   logic irq_q;

   assign ev = {pin_chg[6:3], pin_chg[2:0], log_valid};
   assign sts_clr = (wr_acc && wr_hit(paddr, `BECR_OFF_IRQ_STS)) ?
                    pwdata[`BECR_EV_W-1:0] : '0;

   // new event beats a simultaneous write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= '0;
      end else begin
         sts_q <= (sts_q & ~sts_clr) | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= '0;
      end else if (wr_acc && wr_hit(paddr, `BECR_OFF_IRQ_MASK)) begin
         mask_q <= pwdata[`BECR_EV_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(sts_q & mask_q);
      end
   end

   // ****************************************************************
   // read mux
   // ****************************************************************
   logic [31:0] rd_d;
   logic err_d;

   always_comb begin
      rd_d = 32'h0;
      err_d = 1'b0;
      case (paddr)
         `BECR_OFF_LOG0: rd_d = log_q[31:0];
         `BECR_OFF_LOG1: rd_d = log_q[63:32];
         `BECR_OFF_LOG2: rd_d = log_q[95:64];
         `BECR_OFF_LOG3: rd_d = log_q[127:96];
         // [R07] terminal capability header
         `BECR_OFF_VCHDR: rd_d = {`BECR_VC_NEXT, `BECR_VC_CAP_VER, `BECR_VC_CAP_ID};
         `BECR_OFF_VC0CTL: rd_d = `BECR_VC0CTL_VAL;
         // [R10] sampled pin levels
         `BECR_OFF_XGPIO: rd_d = {17'h0, pin_q[2:0], xg_oe_q, xg_oe_q, xg_out_q, xg_out_q};
         `BECR_OFF_XIO: rd_d = {12'h0, pin_q[6:3], xo_oe_q, xo_oe_q, xo_out_q, xo_out_q};
         `BECR_OFF_TMR: rd_d = {1'b0, tmr_q.ack_en, tmr_q.ack_val, 3'h0,
                                tmr_q.rpl_en, tmr_q.rpl_val};
         `BECR_OFF_IRQ_STS: rd_d = {24'h0, sts_q};
         `BECR_OFF_IRQ_MASK: rd_d = {24'h0, mask_q};
         default: begin
            // [R15] reserved space reads zero, beyond it is an error
            rd_d = 32'h0;
            err_d = (paddr > `BECR_CFG_TOP) || (paddr[1:0] != 2'b00);
         end
      endcase
   end

   // read data frozen at setup so it stands stable through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h0 : rd_d;
         pslverr_q <= err_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign xgpio_out = xg_out_q;
   assign xgpio_oe = xg_oe_q;
   assign gpo_out = xo_out_q;
   assign gpo_oe = xo_oe_q;
   assign tmr = tmr_q;
   assign irq = irq_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   a_log_attr: assert property (@(posedge pclk) disable iff (!por_n) // [R01]
      log_valid |=> log_q[35:0] == {$past(log_txn.attr_cbe), $past(log_txn.attr_ad)})
      else $error("attribute phase not logged");

   a_log_cmd_lo: assert property (@(posedge pclk) disable iff (!por_n) // [R02]
      log_valid |=> log_q[39:36] == $past(log_txn.cmd_lo))
      else $error("first command not logged");

   a_log_single: assert property (@(posedge pclk) disable iff (!por_n) // [R03]
      log_valid && !log_txn.dac |=> log_q[63:40] == 24'h0 && log_q[127:96] == 32'h0)
      else $error("single address log has upper fields");

   a_log_addr_lo: assert property (@(posedge pclk) disable iff (!por_n) // [R04]
      log_valid |=> log_q[95:64] == $past(log_txn.addr_lo))
      else $error("first address not logged");

   a_log_dac: assert property (@(posedge pclk) disable iff (!por_n) // [R05]
      log_valid && log_txn.dac |=> log_q[127:96] == $past(log_txn.addr_hi)
         && log_q[43:40] == $past(log_txn.cmd_hi))
      else $error("dual address phase not logged");

   a_log_sticky: assert property (@(posedge pclk) disable iff (!por_n) // [R06]
      !log_valid |=> $stable(log_q))
      else $error("log changed without capture");

   a_vc_header: assert property (@(posedge pclk) disable iff (!presetn) // [R07]
      setup && !pwrite && paddr == `BECR_OFF_VCHDR |=> prdata == 32'h0001_0002)
      else $error("capability header wrong");

   a_xgpio_clr: assert property (@(posedge pclk) disable iff (!presetn) // [R08]
      xg_wr && pwdata[0] && !pwdata[3] |=> !xgpio_out[0] ##1 $stable(xgpio_out[0]) || xg_wr)
      else $error("gpio output not cleared");

   a_xgpio_oe: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
      xg_wr && pwdata[11] |=> xgpio_oe[2])
      else $error("gpio enable not set");

   a_gpi_read: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      setup && !pwrite && paddr == `BECR_OFF_XIO |=> prdata[19:16] == $past(pin_q[6:3])
         && prdata[31:20] == 12'h0)
      else $error("extra input read wrong");

   a_gpo_set: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      xo_wr && pwdata[7] |=> gpo_out[3])
      else $error("extra output not set");

   a_gpo_oe_clr: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
      xo_wr && pwdata[8] && !pwdata[12] |=> !gpo_oe[0])
      else $error("extra enable not cleared");

   a_ack_timer: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      wr_acc && paddr == `BECR_OFF_TMR |=> tmr.ack_val == $past(pwdata[29:16])
         && tmr.ack_en == $past(pwdata[30]))
      else $error("ack latency not written");

   a_replay_tmr: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
      wr_acc && paddr == `BECR_OFF_TMR |=> tmr.rpl_val == $past(pwdata[11:0]))
      else $error("replay timer not written");

   a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      setup && paddr == 13'h0308 |=> prdata == 32'h0 && !pslverr)
      else $error("reserved offset not zero");

   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      (sts_q & mask_q) != '0 |=> irq)
      else $error("interrupt not raised");

endmodule : becr_regs

/* tb/tb_top.sv */
/*
 * Self-checking bench of the bridge extended configuration register bank.
 * Assumes becr_pkg and becr_defines.svh, one pclk domain, APB answers
 * within 50 cycles, pins driven directly by the bench.
 */
`timescale 1ns/100ps
`include "becr_defines.svh"

module tb_top
   import becr_pkg::*;
   ;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic por_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [12:0] paddr = 13'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic log_valid = 1'b0;
   becr_txn_t log_txn = '0;
   logic [2:0] xgpio_in = 3'h0;
   logic [2:0] xgpio_out;
   logic [2:0] xgpio_oe;
   logic [3:0] gpi_in = 4'h0;
   logic [3:0] gpo_out;
   logic [3:0] gpo_oe;
   becr_tmr_t tmr;
   logic irq;
   int mismatches = 0;
   int comparisons = 0;
   logic [32:0] exp_q [$];
   logic [32:0] msk_q [$];
   logic [32:0] mon_e;
   logic [32:0] mon_m;
   logic [12:0] vc_a [7] = '{13'h150, 13'h154, 13'h158, 13'h15c, 13'h160, 13'h164, 13'h168};
   logic [31:0] vc_v [7] = '{32'h0001_0002, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8000_00ff, 32'h0};
   logic [12:0] rs_a [7] = '{13'h14c, 13'h16c, 13'h2fc, 13'h308, 13'h30c, 13'h314, 13'hffc};

   always #4 pclk = ~pclk;

   becr_regs i_dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .log_valid(log_valid), .log_txn(log_txn),
      .xgpio_in(xgpio_in), .xgpio_out(xgpio_out), .xgpio_oe(xgpio_oe), .gpi_in(gpi_in),
      .gpo_out(gpo_out), .gpo_oe(gpo_oe), .tmr(tmr), .irq(irq));

   // ***************************************
   // shared tasks
   // ***************************************
   task automatic check(input logic [32:0] seen, input logic [32:0] expd);
      comparisons++;
      if (seen !== expd) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize

   // whole APB transfer; the expectation is noted before the answer comes
   task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d,
      input logic [32:0] e, input logic [32:0] m);
      int n;
      n = 0;
      @(posedge pclk);
      exp_q.push_back(e);
      msk_q.push_back(m);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [12:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e}, 33'h1_ffff_ffff);
   endtask : rd

   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
   endtask : wr

   task automatic pulse_log(input becr_txn_t t);
      @(posedge pclk);
      log_valid <= 1'b1;
      log_txn <= t;
      @(posedge pclk);
      log_valid <= 1'b0;
   endtask : pulse_log

   task automatic do_reset(input logic por);
      @(posedge pclk);
      presetn <= 1'b0;
      if (por) por_n <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
   endtask : do_reset

   // ***************************************
   // result watcher
   // ***************************************
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            mismatches++;
         end else begin
            mon_e = exp_q.pop_front();
            mon_m = msk_q.pop_front();
            check({pslverr, prdata} & mon_m, mon_e & mon_m);
         end
      end
   end

   initial begin
      #(8 * 20000);
      mismatches++;
      summarize();
   end

   // ***************************************
   // main sequence
   // ***************************************
   initial begin
      logic [2:0] xo, xe, xi;
      logic [3:0] go, ge, gi;
      logic [31:0] d;
      logic [31:0] lw [4];
      becr_txn_t t;
      void'($urandom(19495));
      xo = 3'h0;
      xe = 3'h0;
      go = 4'h0;
      ge = 4'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      por_n <= 1'b1;
      @(negedge pclk);
      check({26'h0, xgpio_oe, xgpio_out, irq}, 33'h0);
      check({25'h0, gpo_oe, gpo_out}, 33'h0);
      rd(13'h310, 32'h00cd_0115);
      check({5'h0, tmr}, {5'h0, 14'h00cd, 1'b0, 12'h115, 1'b0});
      for (int i = 0; i < 4; i++) rd(13'h13c + 13'(4 * i), 32'h0);
      for (int i = 0; i < 7; i++) begin
         wr(vc_a[i], 32'hffff_ffff);
         rd(vc_a[i], vc_v[i]);
         wr(rs_a[i], 32'hffff_ffff);
         rd(rs_a[i], 32'h0);
      end
      apb(1'b0, 13'h1ffc, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
      apb(1'b1, 13'h1ffc, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
      apb(1'b0, 13'h0302, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
      d = $urandom;
      wr(13'h310, d);
      rd(13'h310, d & 32'h7fff_1fff);
      @(negedge pclk);
      check({5'h0, tmr}, {5'h0, d[29:16], d[30], d[11:0], d[12]});
      @(posedge pclk);
      xi = 3'($urandom);
      gi = 4'($urandom);
      xgpio_in <= xi;
      gpi_in <= gi;
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 10; i++) begin
         d = $urandom & 32'h0000_ffff;
         wr(13'h300, d);
         xo = (xo & ~d[2:0]) | d[5:3];
         xe = (xe & ~d[8:6]) | d[11:9];
         @(negedge pclk);
         check({27'h0, xgpio_oe, xgpio_out}, {27'h0, xe, xo});
         rd(13'h300, {17'h0, xi, xe, xe, xo, xo});
         wr(13'h304, d);
         go = (go & ~d[3:0]) | d[7:4];
         ge = (ge & ~d[11:8]) | d[15:12];
         @(negedge pclk);
         check({25'h0, gpo_oe, gpo_out}, {25'h0, ge, go});
         rd(13'h304, {12'h0, gi, ge, ge, go, go});
      end
      t = becr_txn_t'(109'({$urandom, $urandom, $urandom, $urandom}));
      t.dac = 1'b1;
      lw[0] = t.attr_ad;
      lw[1] = {20'h0, t.cmd_hi, t.cmd_lo, t.attr_cbe};
      lw[2] = t.addr_lo;
      lw[3] = t.addr_hi;
      wr(13'h1000, 32'h0000_00ff);
      wr(13'h1004, 32'h0000_0001);
      rd(13'h1004, 32'h0000_0001);
      pulse_log(t);
      repeat (2) @(negedge pclk);
      check({32'h0, irq}, 33'h1);
      for (int i = 0; i < 4; i++) begin
         wr(13'h13c + 13'(4 * i), ~lw[i]);
         rd(13'h13c + 13'(4 * i), lw[i]);
      end
      rd(13'h1000, 32'h0000_0001);
      wr(13'h1000, 32'h0000_0001);
      repeat (2) @(negedge pclk);
      check({32'h0, irq}, 33'h0);
      wr(13'h1004, 32'h0000_00f0);
      // single address capture: upper command and address must read zero
      t.dac = 1'b0;
      pulse_log(t);
      repeat (2) @(negedge pclk);
      check({32'h0, irq}, 33'h0);
      @(posedge pclk);
      gpi_in <= gi ^ 4'h1;
      repeat (8) @(negedge pclk);
      check({32'h0, irq}, 33'h1);
      rd(13'h1000, 32'h0000_0011);
      // sticky log outlives the ordinary reset only
      do_reset(1'b0);
      rd(13'h140, {24'h0, lw[1][7:0]});
      rd(13'h144, lw[2]);
      rd(13'h148, 32'h0);
      rd(13'h310, 32'h00cd_0115);
      @(negedge pclk);
      check({32'h0, irq}, 33'h0);
      do_reset(1'b1);
      rd(13'h144, 32'h0);
      rd(13'h148, 32'h0);
      repeat (4) @(posedge pclk);
      if (exp_q.size() != 0) mismatches++;
      summarize();
   end
endmodule : tb_top
